// >>> lqm_consts.vh
`ifndef LQM_CONSTS_VH
`define LQM_CONSTS_VH

// ----------------------------------------
// register offsets (index x4 = byte address)
// ----------------------------------------
`define LQM_IDX_VAR_CTRL 8'h1a
`define LQM_IDX_VAR_SUM 8'h1b
`define LQM_IDX_MON_CTRL 8'h1d
`define LQM_IDX_PARAM_IN 8'h20
`define LQM_IDX_THRESH_LO 8'h21
`define LQM_IDX_THRESH_HI 8'h22
`define LQM_IDX_IRQ_STATUS 8'h23
`define LQM_IDX_IRQ_MASK 8'h24
`define LQM_IDX_LINK_CFG 8'h25

// ----------------------------------------
// field positions
// ----------------------------------------
`define LQM_MON_ON_BIT 15
`define LQM_VAR_RDY_BIT 15
`define LQM_VAR_HOLD_BIT 3
`define LQM_VAR_EN_BIT 0
`define LQM_NPARAM 5
`define LQM_PW 16

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define LQM_MON_RESET 16'h0000
`define LQM_VAR_RESET 16'h0000
`define LQM_THR_LO_RESET 16'h0000
`define LQM_THR_HI_RESET 16'hffff
// one period unit: 1048576 ns = 41943 cycles of a 25 ns clock
`define LQM_UNIT_NS 1048576
`define LQM_CLK_NS 25
`define LQM_UNIT_CYC ((`LQM_UNIT_NS) / (`LQM_CLK_NS))

`endif

// >>> lqm_period_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "lqm_consts.vh"

// variance period timer: units of UNIT_CYC, 2/4/6/8 units per period
module lqm_period_timer #(
  parameter UNIT_CYC = `LQM_UNIT_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire run,
  input wire restart,
  input wire [1:0] sel,
  output reg elapsed_r
);
  reg [23:0] cyc_r;
  reg [3:0] unit_r;
  wire [3:0] units_needed;
  wire unit_done;

  // sel 0..3 maps to 2,4,6,8 units
  assign units_needed = {1'b0, sel, 1'b0} + 4'h2;
  assign unit_done = (cyc_r == UNIT_CYC[23:0] - 24'h000001);

  // counter runs only while enabled; a restart drops partial progress
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cyc_r <= 24'h000000;
      unit_r <= 4'h0;
      elapsed_r <= 1'b0;
    end
    else
    begin
      elapsed_r <= 1'b0;
      if (restart || !run)
      begin
        cyc_r <= 24'h000000;
        unit_r <= 4'h0;
      end
      else if (unit_done)
      begin
        cyc_r <= 24'h000000;
        if (unit_r + 4'h1 == units_needed)
        begin
          unit_r <= 4'h0;
          elapsed_r <= 1'b1;
        end
        else
          unit_r <= unit_r + 4'h1;
      end
      else
        cyc_r <= cyc_r + 24'h000001;
    end
  end
endmodule
`default_nettype wire

// >>> lqm_regs.v
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lqm_consts.vh"

module lqm_regs #(
  parameter UNIT_CYC = `LQM_UNIT_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire link_100_ok,
  input wire [79:0] dsp_params,
  input wire [31:0] variance_in,
  output reg dsp_restart_r,
  output reg link_drop_r,
  output reg irq_r
);
  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  reg dp_wr_r;
  reg dp_rd_r;
  reg [7:0] dp_idx_r;
  wire ap_valid;
  assign ap_valid = hsel && htrans[1] && hready;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_idx_r <= 8'h00;
    end
    else
    begin
      dp_wr_r <= ap_valid && hwrite;
      dp_rd_r <= ap_valid && !hwrite;
      dp_idx_r <= haddr[9:2];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] mon_r;
  reg var_en_r;
  reg var_hold_r;
  reg [1:0] var_sel_r;
  reg var_rdy_r;
  reg [31:0] var_sum_r;
  reg var_half_r;
  reg [4:0] param_sel_r;
  reg [79:0] thr_lo_r;
  reg [79:0] thr_hi_r;
  reg signal_detect_option_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg var_restart_r;
  wire var_elapsed;
  wire [9:0] viol;
  wire [4:0] param_viol;
  wire mon_active;
  wire wr_var_ctrl;
  wire rd_var_sum;
  wire rd_mon;
  wire [15:0] wd;

  assign wd = hwdata[15:0];
  assign wr_var_ctrl = dp_wr_r && (dp_idx_r == `LQM_IDX_VAR_CTRL);
  assign rd_var_sum = dp_rd_r && (dp_idx_r == `LQM_IDX_VAR_SUM);
  assign rd_mon = dp_rd_r && (dp_idx_r == `LQM_IDX_MON_CTRL);
  assign mon_active = mon_r[`LQM_MON_ON_BIT] && link_100_ok;

  // ----------------------------------------
  // per-parameter comparison
  // ----------------------------------------
  // parameter order 0..4: eq coeff, gain, wander, freq offset, freq control
  genvar g;
  generate
    for (g = 0; g < `LQM_NPARAM; g = g + 1)
    begin : g_cmp
      wire [15:0] p;
      assign p = dsp_params[g*16 +: 16];
      assign viol[2*g+1] = mon_active && (p > thr_hi_r[g*16 +: 16]);
      assign viol[2*g] = mon_active && (p < thr_lo_r[g*16 +: 16]);
      assign param_viol[g] = mon_r[10+g] && (viol[2*g+1] || viol[2*g]);
    end
  endgenerate

  lqm_period_timer #(
    .UNIT_CYC(UNIT_CYC)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(var_en_r),
    .restart(var_restart_r),
    .sel(var_sel_r),
    .elapsed_r(var_elapsed)
  );

  // ----------------------------------------
  // monitor register and warnings
  // ----------------------------------------
  // set wins over clear-on-read so no violation is missed
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mon_r <= `LQM_MON_RESET;
    else
    begin
      if (dp_wr_r && dp_idx_r == `LQM_IDX_MON_CTRL)
        mon_r[15:10] <= wd[15:10];
      mon_r[9:0] <= (rd_mon ? 10'h000 : mon_r[9:0]) | viol;
    end
  end

  // ----------------------------------------
  // dsp restart and link drop
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dsp_restart_r <= 1'b0;
      link_drop_r <= 1'b0;
    end
    else
    begin
      dsp_restart_r <= |param_viol;
      link_drop_r <= (|param_viol) && !signal_detect_option_r;
    end
  end

  // ----------------------------------------
  // variance control and readout
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      var_en_r <= 1'b0;
      var_hold_r <= 1'b0;
      var_sel_r <= 2'b00;
      var_rdy_r <= 1'b0;
      var_sum_r <= 32'h00000000;
      var_half_r <= 1'b0;
      var_restart_r <= 1'b0;
    end
    else
    begin
      var_restart_r <= 1'b0;
      if (wr_var_ctrl)
      begin
        var_en_r <= wd[`LQM_VAR_EN_BIT];
        var_hold_r <= wd[`LQM_VAR_HOLD_BIT];
        var_sel_r <= wd[2:1];
        var_restart_r <= (wd[2:1] != var_sel_r);
        // setting hold starts a fresh low/high pairing
        if (wd[`LQM_VAR_HOLD_BIT] && !var_hold_r)
          var_half_r <= 1'b0;
      end
      if (var_elapsed && !var_hold_r)
      begin
        var_sum_r <= variance_in;
        var_rdy_r <= 1'b1;
      end
      if (rd_var_sum)
      begin
        var_half_r <= ~var_half_r;
        if (var_half_r)
        begin
          var_rdy_r <= var_elapsed && !var_hold_r;
          var_hold_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // thresholds, link config, interrupt
  // ----------------------------------------
  // threshold entry
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      param_sel_r <= 5'h00;
      thr_lo_r <= {`LQM_NPARAM{`LQM_THR_LO_RESET}};
      thr_hi_r <= {`LQM_NPARAM{`LQM_THR_HI_RESET}};
      signal_detect_option_r <= 1'b0;
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      irq_r <= 1'b0;
    end
    else
    begin
      if (dp_wr_r && dp_idx_r == `LQM_IDX_PARAM_IN)
        param_sel_r <= {2'b00, hwdata[2:0]};
      if (dp_wr_r && dp_idx_r == `LQM_IDX_THRESH_LO && param_sel_r < 5'd5)
        thr_lo_r[param_sel_r*16 +: 16] <= wd;
      if (dp_wr_r && dp_idx_r == `LQM_IDX_THRESH_HI && param_sel_r < 5'd5)
        thr_hi_r[param_sel_r*16 +: 16] <= wd;
      if (dp_wr_r && dp_idx_r == `LQM_IDX_LINK_CFG)
        signal_detect_option_r <= hwdata[0];
      if (dp_wr_r && dp_idx_r == `LQM_IDX_IRQ_MASK)
        irq_mask_r <= hwdata[1:0];
      // bit0 quality violation, bit1 variance ready; w1c, set wins
      // violation and variance-ready interrupt
      irq_stat_r <= (irq_stat_r & ~((dp_wr_r && dp_idx_r == `LQM_IDX_IRQ_STATUS) ? hwdata[1:0] : 2'b00))
                    | {var_elapsed && !var_hold_r, |viol};
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // read mux and response
  // ----------------------------------------
  // single 16-bit window
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      if (ap_valid && !hwrite)
      begin
        case (haddr[9:2])
          `LQM_IDX_VAR_CTRL:
            hrdata <= {16'h0000, var_rdy_r, 11'h000, var_hold_r, var_sel_r, var_en_r};
          `LQM_IDX_VAR_SUM:
            hrdata <= {16'h0000, var_half_r ? var_sum_r[31:16] : var_sum_r[15:0]};
          `LQM_IDX_MON_CTRL:
            hrdata <= {16'h0000, mon_r[15:10], mon_r[9:0] | viol};
          `LQM_IDX_PARAM_IN:
            hrdata <= {27'h0000000, param_sel_r};
          `LQM_IDX_THRESH_LO:
            hrdata <= {16'h0000, (param_sel_r < 5'd5) ? thr_lo_r[param_sel_r*16 +: 16] : 16'h0000};
          `LQM_IDX_THRESH_HI:
            hrdata <= {16'h0000, (param_sel_r < 5'd5) ? thr_hi_r[param_sel_r*16 +: 16] : 16'h0000};
          `LQM_IDX_IRQ_STATUS:
            hrdata <= {30'h00000000, irq_stat_r};
          `LQM_IDX_IRQ_MASK:
            hrdata <= {30'h00000000, irq_mask_r};
          `LQM_IDX_LINK_CFG:
            hrdata <= {31'h00000000, signal_detect_option_r};
          default:
            hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> lqm_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port-level checks of the register bank
// ----------------------------------------
module lqm_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire link_100_ok,
  input wire dsp_restart_r,
  input wire link_drop_r,
  input wire irq_r
);
  logic rd_q;
  logic [31:0] a_q;
  // read data phase tracker, registered to line up with hrdata
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      a_q <= 32'h0;
    end
    else
    begin
      rd_q <= hsel && htrans[1] && hready && !hwrite;
      a_q <= haddr;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_idle: assert property (hrdata != 32'h0 |-> rd_q) else $error("hrdata outside read");
  a_mon_upper: assert property (rd_q && a_q == 32'h74 |-> hrdata[31:16] == 16'h0)
    else $error("monitor upper bits set");
  a_sum_upper: assert property (rd_q && a_q == 32'h6c |-> hrdata[31:16] == 16'h0)
    else $error("sum upper bits set");
  a_ctrl_rsvd: assert property (rd_q && a_q == 32'h68 |-> hrdata[14:4] == 11'h0)
    else $error("control reserved bits set");
  a_drop_restart: assert property (link_drop_r |-> dsp_restart_r) else $error("drop without restart");
  a_restart_link: assert property (dsp_restart_r |-> $past(link_100_ok))
    else $error("restart without link");
  c_drop: cover property (dsp_restart_r && link_drop_r);
  c_irq: cover property ($rose(irq_r));
  c_sum: cover property (rd_q && a_q == 32'h6c && hrdata != 32'h0);
endmodule
bind lqm_regs lqm_chk i_lqm_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .link_100_ok(link_100_ok), .dsp_restart_r(dsp_restart_r),
  .link_drop_r(link_drop_r), .irq_r(irq_r));
`default_nettype wire

// >>> lqm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// management host, single ahb transfers
// ----------------------------------------
module lqm_host_model (
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b0, 32'h0, 2'b00, 1'b0, 3'h2, 32'h0};
  // bounded wait for hready at a rising edge
  task automatic step(inout bit to);
    int n;
    n = 0;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 64);
    to |= (n >= 64);
  endtask
  task automatic xfer(input [31:0] a, input w, input [31:0] d, output [31:0] r, output bit to);
    to = 0;
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'b10};
    step(to);
    // a read leaves hwdata inverted so a stale value never looks valid
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, w ? d : ~hwdata};
    step(to);
    r = hrdata;
  endtask
  // thresholds go through select and threshold registers
  task automatic set_thr(input int p, input [15:0] lo, input [15:0] hi, output bit to);
    logic [31:0] r;
    bit t1, t2, t3;
    xfer(32'h80, 1'b1, p, r, t1);
    xfer(32'h84, 1'b1, {16'h0, lo}, r, t2);
    xfer(32'h88, 1'b1, {16'h0, hi}, r, t3);
    to = t1 | t2 | t3;
  endtask
  // wait for ready, then freeze the sum
  task automatic var_hold(input [31:0] ctl, output int c, output bit to);
    logic [31:0] r;
    bit t;
    c = 0;
    to = 0;
    do begin xfer(32'h68, 1'b0, 32'h0, r, t); to |= t; c += 2; end while (!r[15] && c < 400);
    xfer(32'h68, 1'b1, ctl | 32'h8, r, t);
    to |= t | (c >= 400);
  endtask
  // two reads of the sum give both halves
  task automatic var_pair(output [31:0] lo, output [31:0] hi, output bit to);
    bit t0, t1;
    xfer(32'h6c, 1'b0, 32'h0, lo, t0);
    xfer(32'h6c, 1'b0, 32'h0, hi, t1);
    to = t0 | t1;
  endtask
endmodule
`default_nettype wire

// >>> lqm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk, hresetn, link_100_ok, hsel, hwrite, hreadyout, hresp, dsp_restart_r, link_drop_r, irq_r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, variance_in, r, lo, hi, m;
  logic [79:0] dsp_params;
  int error_cnt, n_checks, rs_n, dr_n, rs0, dr0, c;
  bit t;
  lqm_regs #(.UNIT_CYC(4)) i_lqm_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_100_ok(link_100_ok),
    .dsp_params(dsp_params), .variance_in(variance_in), .dsp_restart_r(dsp_restart_r),
    .link_drop_r(link_drop_r), .irq_r(irq_r));
  lqm_host_model i_lqm_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // restart and drop pulses are counted, one per cycle
  always @(posedge hclk)
  begin
    rs_n <= rs_n + (dsp_restart_r === 1'b1);
    dr_n <= dr_n + (link_drop_r === 1'b1);
  end
  // ----------------------------------------
  // checking and access helpers
  // ----------------------------------------
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo_chk;
    if (t)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic rd(input [31:0] a);
    i_lqm_host_model.xfer(a, 1'b0, 32'h0, r, t);
    tmo_chk();
  endtask
  task automatic wr(input [31:0] a, input [31:0] d);
    i_lqm_host_model.xfer(a, 1'b1, d, r, t);
    tmo_chk();
  endtask
  // parameter p out of range for three cycles, then back in range
  task automatic viol(input int p, input [15:0] v);
    rs0 = rs_n;
    dr0 = dr_n;
    dsp_params[16*p +: 16] <= v;
    repeat (3) @(posedge hclk);
    dsp_params[16*p +: 16] <= 16'h0800;
    repeat (3) @(posedge hclk);
  endtask
  initial
  begin
    {hresetn, link_100_ok, dsp_params, variance_in} = {2'b01, {5{16'h0800}}, 32'h0};
    {rs_n, dr_n, error_cnt, n_checks} = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h74); chk("mon rst", 32'h0, r);
    rd(32'h6c); chk("sum rst", 32'h0, r);
    rd(32'h68); chk("ctrl rst", 32'h0, r);
    rd(32'h1fc); chk("unmapped", 32'h0, r);
    wr(32'h90, 32'h1);
    for (int p = 0; p < 5; p++)
    begin
      i_lqm_host_model.set_thr(p, 16'h0100, 16'h1000, t);
      tmo_chk();
      m = 32'h8000 | (32'h1 << (10 + p));
      wr(32'h74, m);
      for (int h = 0; h < 2; h++)
      begin
        viol(p, h ? 16'h2000 : 16'h0050);
        chk("irq", 32'h1, {31'h0, irq_r});
        chk("restart", 32'h1, {31'h0, rs_n > rs0});
        chk("drop", 32'h1, {31'h0, dr_n > dr0});
        rd(32'h74); chk("warn", m | (32'h1 << (2 * p + h)), r);
        rd(32'h74); chk("warn clr", m, r);
        wr(32'h8c, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq clr", 32'h0, {31'h0, irq_r});
      end
    end
    wr(32'h94, 32'h1);
    viol(4, 16'h2000);
    chk("sd restart", 32'h1, {31'h0, rs_n > rs0});
    chk("sd no drop", 32'h0, {31'h0, dr_n > dr0});
    rd(32'h74);
    link_100_ok <= 1'b0;
    viol(4, 16'h2000);
    chk("no link", 32'h0, {31'h0, rs_n > rs0});
    rd(32'h74); chk("no link warn", m, r);
    link_100_ok <= 1'b1;
    i_lqm_host_model.set_thr(4, 16'h0000, 16'hffff, t);
    tmo_chk();
    viol(4, 16'hffff);
    viol(4, 16'h0000);
    rd(32'h74); chk("off warn", m, r);
    for (int s = 0; s < 4; s++)
    begin
      wr(32'h68, 32'h0);
      i_lqm_host_model.var_pair(lo, hi, t);
      tmo_chk();
      variance_in <= 32'h1234_5678 + s;
      wr(32'h68, (s << 1) | 1);
      i_lqm_host_model.var_hold((s << 1) | 1, c, t);
      tmo_chk();
      chk("period", 1, {31'h0, c >= 8 * (s + 1) - 2 && c <= 8 * (s + 1) + 4});
      variance_in <= 32'h0f0f_f0f0;
      repeat (40) @(posedge hclk);
      i_lqm_host_model.var_pair(lo, hi, t);
      tmo_chk();
      chk("sum lo", 32'h5678 + s, lo);
      chk("sum hi", 32'h1234, hi);
      rd(32'h68); chk("auto clr", (s << 1) | 1, r);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
